// ==== logic/cg_clock_ctrl.sv ====
// Behaviour
// - Main crystal stops on deep sleep or main halt bit.
// - After reset the fast internal oscillator drives the CPU.
// - Fast internal oscillator stops on deep sleep or its halt bit.
// - Option byte sets fast frequency; register changes it, 64 MHz max.
// - External main clock input blocked on deep sleep or main halt bit.
// - Subsystem crystal stops when the subsystem halt bit is set.
// - External subsystem input blocked when the subsystem halt bit is set.
// - Low-speed clock feeds CPU, watchdog, RTC, interval timer and timer A.
// - PLL selectable as system clock; reference is external or fast internal.
`timescale 1ns/1ps
module cg_clock_ctrl
    import cg_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic reset,
    // APB slave
    input cg_apb_req_t apbReq,
    output cg_apb_rsp_t apbRsp,
    // Power mode events
    input logic deepSleepCmd,
    input logic wakeEvent,
    // Option byte frequency code
    input logic [2:0] optFreq,
    // Source ticks, indexed by cg_src_t
    input logic [NSRC-1:0] srcTick,
    // Oscillator controls
    output cg_run_t oscRun,
    output logic [2:0] fastFreq,
    output logic pllRefInternal,
    // Clock outputs
    output logic sysTick,
    output cg_src_t curSrc,
    output cg_low_t lowTicks
);

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [2:0] clampFreq(input logic [2:0] code);
        clampFreq = (code > FREQ_MAX) ? FREQ_MAX : code;
    endfunction

    function automatic logic [NSRC-1:0] srcBit(input cg_src_t src);
        srcBit = NSRC'(1) << src;
    endfunction

    cg_main_st_t st_r;
    cg_main_st_t st_nxt;
    logic [NSRC-1:0] runVec;
    logic [NSRC-1:0] gateEn;
    logic [NSRC-1:0] gated;
    logic access;
    logic done;

    // -------------------------------------------------------------
    // Source availability and gate requests
    // -------------------------------------------------------------
    always_comb
    begin
        runVec[SRC_FAST] = st_r.run.fast;
        runVec[SRC_MAIN_XT] = st_r.run.mainXt;
        runVec[SRC_EXT_MAIN] = st_r.run.extMain;
        runVec[SRC_SUB_XT] = st_r.run.subXt;
        runVec[SRC_EXT_SUB] = st_r.run.extSub;
        runVec[SRC_LOW] = 1'b1;
        // PLL runs only while its reference runs
        runVec[SRC_PLL] = st_r.pllRef ? st_r.run.fast
                                      : st_r.run.extMain;
        case (st_r.sw)
            SW_IDLE: gateEn = srcBit(st_r.cur) & runVec;
            SW_ARM: gateEn = srcBit(st_r.tgt) & runVec;
            default: gateEn = '0;
        endcase
    end

    // One glitch-free gate per source
    for (genvar i = 0; i < NSRC; i++)
    begin : gGate
        cg_src_gate uGate (
            .clk(clk),
            .reset(reset),
            .tick(srcTick[i]),
            .enable(gateEn[i]),
            .gatedTick(gated[i])
        );
    end

    assign access = apbReq.psel & apbReq.penable;
    assign done = access & st_r.rsp.pready;

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // APB: one wait state, answer registered
        st_nxt.rsp.pready = access & !st_r.rsp.pready;
        st_nxt.rsp.pslverr = 1'b0;
        st_nxt.rsp.prdata = 32'h0;
        if (access && !st_r.rsp.pready)
        begin
            case (apbReq.paddr)
                ADDR_CTRL: st_nxt.rsp.prdata[2:0] = st_r.halt;
                ADDR_SEL:
                begin
                    st_nxt.rsp.prdata[2:0] = st_r.sel;
                    st_nxt.rsp.prdata[SEL_REF_BIT] = st_r.pllRef;
                end
                ADDR_FREQ: st_nxt.rsp.prdata[2:0] = st_r.freq;
                ADDR_LSEN: st_nxt.rsp.prdata[3:0] = st_r.lsen;
                ADDR_STAT:
                begin
                    st_nxt.rsp.prdata[2:0] = st_r.cur;
                    st_nxt.rsp.prdata[STAT_BUSY] = (st_r.sw != SW_IDLE);
                    st_nxt.rsp.prdata[STAT_SLEEP] = st_r.sleep;
                    st_nxt.rsp.prdata[STAT_RUN_LSB+:5] = st_r.run;
                end
                default: st_nxt.rsp.pslverr = 1'b1;
            endcase
        end

        // Register writes at the completing edge
        if (done && apbReq.pwrite)
        begin
            case (apbReq.paddr)
                ADDR_CTRL: st_nxt.halt = apbReq.pwdata[2:0];
                ADDR_SEL:
                begin
                    if (apbReq.pwdata[2:0] <= 3'(SRC_PLL))
                    begin
                        st_nxt.sel = cg_src_t'(apbReq.pwdata[2:0]);
                    end
                    st_nxt.pllRef = apbReq.pwdata[SEL_REF_BIT];
                end
                ADDR_FREQ:
                begin
                    st_nxt.freq = clampFreq(apbReq.pwdata[2:0]);
                end
                ADDR_LSEN: st_nxt.lsen = apbReq.pwdata[3:0];
                default: st_nxt.lsen = st_r.lsen;
            endcase
        end

        // Option byte loads once after reset release
        if (!st_r.optDone)
        begin
            st_nxt.optDone = 1'b1;
            st_nxt.freq = clampFreq(optFreq);
        end

        // Deep sleep: entry wins over wake
        st_nxt.sleep = deepSleepCmd | (st_r.sleep & !wakeEvent);

        // Oscillator and input gate controls
        st_nxt.run.mainXt = !st_r.halt[CTRL_MAIN] & !st_r.sleep;
        st_nxt.run.extMain = !st_r.halt[CTRL_MAIN] & !st_r.sleep;
        st_nxt.run.fast = !st_r.halt[CTRL_FAST] & !st_r.sleep;
        st_nxt.run.subXt = !st_r.halt[CTRL_SUB];
        st_nxt.run.extSub = !st_r.halt[CTRL_SUB];

        // Source switch: drain old, break cycle, arm new
        case (st_r.sw)
            SW_IDLE:
            begin
                if (st_r.sel != st_r.cur)
                begin
                    st_nxt.tgt = st_r.sel;
                    st_nxt.sw = SW_DRAIN;
                end
            end
            SW_DRAIN:
            begin
                if (!srcTick[st_r.cur])
                begin
                    st_nxt.sw = SW_ARM;
                end
            end
            SW_ARM:
            begin
                if (st_r.sel != st_r.tgt)
                begin
                    st_nxt.cur = st_r.tgt;
                    st_nxt.tgt = st_r.sel;
                    st_nxt.sw = SW_DRAIN;
                end
                else if (gated[st_r.tgt])
                begin
                    st_nxt.cur = st_r.tgt;
                    st_nxt.sw = SW_IDLE;
                end
            end
            default: st_nxt.sw = SW_IDLE;
        endcase

        // Clock outputs
        st_nxt.sysTick = |gated;
        st_nxt.low.wdt = srcTick[SRC_LOW] & st_r.lsen[0];
        st_nxt.low.rtc = srcTick[SRC_LOW] & st_r.lsen[1];
        st_nxt.low.itv = srcTick[SRC_LOW] & st_r.lsen[2];
        st_nxt.low.tmra = srcTick[SRC_LOW] & st_r.lsen[3];
    end

    // State register, fast oscillator selected at reset
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= MAIN_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign apbRsp = st_r.rsp;
    assign oscRun = st_r.run;
    assign fastFreq = st_r.freq;
    assign pllRefInternal = st_r.pllRef;
    assign sysTick = st_r.sysTick;
    assign curSrc = st_r.cur;
    assign lowTicks = st_r.low;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence swDrain;
        st_r.sw == SW_DRAIN;
    endsequence

    sequence swArmed;
        st_r.sw == SW_ARM && gated[st_r.tgt];
    endsequence

    main_stop_a: assert property (
        (st_r.halt[CTRL_MAIN] || st_r.sleep) |=> !oscRun.mainXt)
        else $error("main crystal kept running");

    reset_src_a: assert property (
        $past(reset) |-> curSrc == SRC_FAST && st_r.sel == SRC_FAST)
        else $error("fast oscillator not selected after reset");

    fast_stop_a: assert property (
        (st_r.halt[CTRL_FAST] || st_r.sleep) |=> !oscRun.fast)
        else $error("fast oscillator kept running");

    freq_limit_a: assert property (
        st_r.optDone |-> fastFreq <= FREQ_MAX &&
        (!$past(st_r.optDone) -> fastFreq == clampFreq($past(optFreq))))
        else $error("fast frequency out of range or not loaded");

    ext_main_a: assert property (
        $rose(st_r.sleep) |=> !oscRun.extMain [*2])
        else $error("external main input not blocked");

    sub_stop_a: assert property (
        st_r.halt[CTRL_SUB] |=> !oscRun.subXt && !oscRun.extSub)
        else $error("subsystem source not stopped");

    low_tick_a: assert property (
        lowTicks.wdt |-> $past(srcTick[SRC_LOW]) && $past(st_r.lsen[0]))
        else $error("watchdog tick without low-speed tick");

    pll_ref_a: assert property (
        done && apbReq.pwrite && apbReq.paddr == ADDR_SEL |=>
        pllRefInternal == $past(apbReq.pwdata[SEL_REF_BIT]))
        else $error("PLL reference select not taken");

    switch_gap_a: assert property (
        swDrain |-> gateEn == '0 ##1 $onehot0(gateEn))
        else $error("two sources gated at once");

    switch_done_a: assert property (
        swArmed and (st_r.sel == st_r.tgt) |=>
        st_r.sw == SW_IDLE && curSrc == $past(st_r.tgt) && sysTick)
        else $error("switch did not complete on first new tick");

    apb_answer_a: assert property (
        access && !apbRsp.pready |=> apbRsp.pready ##1 !apbRsp.pready)
        else $error("APB answer not one cycle");

    // Fast oscillator back as soon as halt and sleep are gone
    fast_run_a: assert property (
        !st_r.halt[CTRL_FAST] && !st_r.sleep |=> oscRun.fast)
        else $error("fast oscillator not restarted");

    low_rtc_a: assert property (
        lowTicks.rtc |-> $past(srcTick[SRC_LOW]) && $past(st_r.lsen[1]))
        else $error("RTC tick without low-speed tick");

    // Unused source code leaves the selection alone
    sel_keep_a: assert property (
        done && apbReq.pwrite && apbReq.paddr == ADDR_SEL &&
        apbReq.pwdata[2:0] == 3'h7 |=> st_r.sel == $past(st_r.sel))
        else $error("invalid source code taken");

endmodule

// ==== logic/cg_pkg.sv ====
package cg_pkg;

    // -------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEL = 8'h04;
    localparam logic [7:0] ADDR_FREQ = 8'h08;
    localparam logic [7:0] ADDR_LSEN = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // Field positions
    localparam int CTRL_MAIN = 0;
    localparam int CTRL_FAST = 1;
    localparam int CTRL_SUB = 2;
    localparam int SEL_REF_BIT = 4;
    localparam int STAT_BUSY = 3;
    localparam int STAT_SLEEP = 4;
    localparam int STAT_RUN_LSB = 8;

    // Values after reset and fast frequency limit
    localparam logic [2:0] CTRL_RST = 3'h5;
    localparam logic [3:0] LSEN_RST = 4'h1;
    localparam logic [2:0] FREQ_RST = 3'h0;
    localparam logic [2:0] FREQ_MAX = 3'h6;

    // Number of clock sources
    localparam int NSRC = 7;

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SRC_FAST = 3'h0,
        SRC_MAIN_XT = 3'h1,
        SRC_EXT_MAIN = 3'h2,
        SRC_SUB_XT = 3'h3,
        SRC_EXT_SUB = 3'h4,
        SRC_LOW = 3'h5,
        SRC_PLL = 3'h6
    } cg_src_t;

    typedef enum logic [1:0]
    {
        SW_IDLE = 2'h0,
        SW_DRAIN = 2'h1,
        SW_ARM = 2'h3
    } cg_sw_t;

    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cg_apb_req_t;

    typedef struct packed
    {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cg_apb_rsp_t;

    // Oscillator run and input gate controls
    typedef struct packed
    {
        logic mainXt;
        logic extMain;
        logic fast;
        logic subXt;
        logic extSub;
    } cg_run_t;

    // Low-speed ticks to peripherals
    typedef struct packed
    {
        logic wdt;
        logic rtc;
        logic itv;
        logic tmra;
    } cg_low_t;

    localparam cg_run_t RUN_RST = 5'h04;

    typedef struct packed
    {
        logic [2:0] halt;
        cg_src_t sel;
        logic pllRef;
        logic [2:0] freq;
        logic [3:0] lsen;
        logic optDone;
        logic sleep;
        cg_src_t cur;
        cg_src_t tgt;
        cg_sw_t sw;
        logic sysTick;
        cg_low_t low;
        cg_run_t run;
        cg_apb_rsp_t rsp;
    } cg_main_st_t;

    localparam cg_main_st_t MAIN_RST = '{
        halt: CTRL_RST,
        sel: SRC_FAST,
        pllRef: 1'b0,
        freq: FREQ_RST,
        lsen: LSEN_RST,
        optDone: 1'b0,
        sleep: 1'b0,
        cur: SRC_FAST,
        tgt: SRC_FAST,
        sw: SW_IDLE,
        sysTick: 1'b0,
        low: 4'h0,
        run: RUN_RST,
        rsp: 34'h0
    };

endpackage

// ==== logic/cg_src_gate.sv ====
`timescale 1ns/1ps
module cg_src_gate
    import cg_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic reset,
    // Source tick and request
    input logic tick,
    input logic enable,
    // Gated tick
    output logic gatedTick
);

    typedef struct packed
    {
        logic en;
        logic out;
    } cg_gate_st_t;

    cg_gate_st_t st_r;
    cg_gate_st_t st_nxt;

    // Enable only moves while the tick is low
    always_comb
    begin
        st_nxt = st_r;
        if (!tick)
        begin
            st_nxt.en = enable;
        end
        st_nxt.out = tick & st_r.en;
    end

    // State register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= 2'h0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign gatedTick = st_r.out;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    gate_hold_a: assert property (@(posedge clk) disable iff (reset)
        $changed(st_r.en) |-> !$past(tick))
        else $error("gate enable moved during a tick");

    gate_pass_a: assert property (@(posedge clk) disable iff (reset)
        gatedTick |-> $past(st_r.en) && $past(tick))
        else $error("tick passed a closed gate");

endmodule

// ==== dv/cg_osc_model.sv ====
`timescale 1ns/1ps
module cg_osc_model
    import cg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Run controls from the block
    input wire cg_run_t oscRun,
    input wire logic pllRefInternal,
    // Source ticks
    output logic [NSRC-1:0] srcTick
);
    logic [9:0] cycleCnt;
    logic [NSRC-1:0] running;

    // ---------------------------------------------------------
    // Source activity
    // ---------------------------------------------------------
    // A halted source gives no ticks at all
    always_comb
    begin
        running[0] = oscRun.fast;
        running[1] = oscRun.mainXt;
        running[2] = oscRun.extMain;
        running[3] = oscRun.subXt;
        running[4] = oscRun.extSub;
        running[5] = 1'b1;
        running[6] = pllRefInternal ? oscRun.fast : oscRun.extMain;
    end

    // Each source ticks at its own rate, never two cycles running
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cycleCnt <= 10'h000;
            srcTick <= '0;
        end
        else
        begin
            // Wrap at a common multiple of all rates: no back-to-back ticks
            if (cycleCnt == 10'h347)
                cycleCnt <= 10'h000;
            else
                cycleCnt <= cycleCnt + 10'h001;
            for (int i = 0; i < NSRC; i++)
                srcTick[i] <= running[i] && (cycleCnt % (i + 2) == 0);
        end
    end
endmodule

// ==== dv/test_cg_clock_ctrl.sv ====
`timescale 1ns/1ps
module test_cg_clock_ctrl;
    import cg_pkg::*;

    // ---------------------------------------------------------
    // Signals
    // ---------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    cg_apb_req_t apbReq = '0;
    cg_apb_rsp_t apbRsp;
    logic deepSleepCmd = 1'b0;
    logic wakeEvent = 1'b0;
    logic [2:0] optFreq = 3'h3;
    logic [NSRC-1:0] srcTick;
    cg_run_t oscRun;
    logic [2:0] fastFreq;
    logic pllRefInternal;
    logic sysTick;
    cg_src_t curSrc;
    cg_low_t lowTicks;
    int failures = 0;
    int checked = 0;
    logic [31:0] rd;
    logic err;

    // Clock at 25 MHz
    always #20 clk = ~clk;

    cg_clock_ctrl u_dut (.clk(clk), .reset(reset), .apbReq(apbReq),
        .apbRsp(apbRsp), .deepSleepCmd(deepSleepCmd),
        .wakeEvent(wakeEvent), .optFreq(optFreq), .srcTick(srcTick),
        .oscRun(oscRun), .fastFreq(fastFreq),
        .pllRefInternal(pllRefInternal), .sysTick(sysTick),
        .curSrc(curSrc), .lowTicks(lowTicks));

    cg_osc_model u_osc (.clk(clk), .reset(reset), .oscRun(oscRun),
        .pllRefInternal(pllRefInternal), .srcTick(srcTick));

    // ---------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
    begin
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    task automatic conclude;
    begin
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] addr, input logic wr,
        input logic [31:0] data);
        int n;
    begin
        n = 0;
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= addr;
        apbReq.pwdata <= data;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (apbRsp.pready !== 1'b1 && n < 20);
        if (n >= 20)
            check("pready", 32'h0, 32'h1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clk);
    end
    endtask

    // Wait for the switch to land on a source
    task automatic waitSrc(input cg_src_t src);
        int n;
    begin
        n = 0;
        while (curSrc !== src && n < 200)
        begin
            @(posedge clk);
            n++;
        end
    end
    endtask

    // ---------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------
    task automatic afterReset;
    begin
        check("curSrc", 32'(curSrc), 32'(SRC_FAST));
        check("oscRun", 32'(oscRun), 32'h04);
        check("fastFreq", 32'(fastFreq), 32'h3);
        apb(ADDR_CTRL, 1'b0, 32'h0);
        check("ctrl", rd, 32'h5);
    end
    endtask

    task automatic freqClamp;
    begin
        apb(ADDR_FREQ, 1'b1, 32'h7);
        apb(ADDR_FREQ, 1'b0, 32'h0);
        check("freq", rd, 32'h6);
        check("fastFreq", 32'(fastFreq), 32'h6);
        apb(8'h2C, 1'b0, 32'h0);
        check("pslverr", 32'(err), 32'h1);
    end
    endtask

    // Each halt bit alone, then all running
    task automatic haltBits;
        logic [2:0] ctrl [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        logic [4:0] run [4] = '{5'h07, 5'h1B, 5'h1C, 5'h1F};
    begin
        for (int i = 0; i < 4; i++)
        begin
            apb(ADDR_CTRL, 1'b1, 32'(ctrl[i]));
            repeat (4) @(posedge clk);
            check("oscRun", 32'(oscRun), 32'(run[i]));
        end
    end
    endtask

    // Every source in turn, PLL from both references
    task automatic switchAll;
        int ticks;
    begin
        for (int s = 0; s < 8; s++)
        begin
            apb(ADDR_SEL, 1'b1, 32'(s[2:0]) | (s == 7 ? 32'h10 : 32'h0));
            waitSrc(cg_src_t'(s == 7 ? 6 : s));
            check("curSrc", 32'(curSrc), (s == 7 ? 32'h6 : 32'(s)));
            ticks = 0;
            repeat (40)
            begin
                @(posedge clk);
                ticks += sysTick ? 1 : 0;
            end
            check("sysTick", 32'(ticks > 0), 32'h1);
        end
        check("pllRef", 32'(pllRefInternal), 32'h1);
        apb(ADDR_SEL, 1'b1, 32'(SRC_LOW));
        waitSrc(SRC_LOW);
        check("curSrc", 32'(curSrc), 32'(SRC_LOW));
    end
    endtask

    task automatic lowPeripherals;
        logic [3:0] seen;
    begin
        apb(ADDR_LSEN, 1'b0, 32'h0);
        check("lsen", rd, 32'h1);
        apb(ADDR_LSEN, 1'b1, 32'hF);
        seen = 4'h0;
        repeat (30)
        begin
            @(posedge clk);
            seen |= lowTicks;
        end
        check("lowTicks", 32'(seen), 32'hF);
    end
    endtask

    // Deep sleep stops main sources, sub keeps going
    task automatic deepSleep;
    begin
        deepSleepCmd <= 1'b1;
        @(posedge clk);
        deepSleepCmd <= 1'b0;
        repeat (4) @(posedge clk);
        check("oscRun", 32'(oscRun), 32'h03);
        apb(ADDR_STAT, 1'b0, 32'h0);
        check("sleeping", 32'(rd[STAT_SLEEP]), 32'h1);
        check("statRun", 32'(rd[STAT_RUN_LSB+:5]), 32'h03);
        wakeEvent <= 1'b1;
        @(posedge clk);
        wakeEvent <= 1'b0;
        repeat (4) @(posedge clk);
        check("oscRun", 32'(oscRun), 32'h1F);
    end
    endtask

    // ---------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        afterReset();
        freqClamp();
        haltBits();
        switchAll();
        lowPeripherals();
        deepSleep();
        conclude();
    end

    initial
    begin
        #(40 * 20000);
        failures++;
        conclude();
    end
endmodule
